// ---- dv/scan_master.sv ----
/*
 * Behavioural board tester that drives the test port with a slow tck.
 * Assumes ref_clk at 100 MHz; tck spends 4 ref_clk cycles low and 4 high.
 */
`timescale 1ns/1ns
module scan_master (
	input  wire logic ref_clk,
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	bit port_bad;
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
		port_bad = 1'b0;
	end
	// One tck period; tdo is taken just before the rise and must hold while high
	task automatic tick(input logic m, input logic d, output logic o, output logic oe);
		@(posedge ref_clk);
		tck <= 1'h0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge ref_clk);
		o = tdo;
		oe = tdo_oe;
		tck <= 1'h1;
		repeat (3) @(posedge ref_clk);
		if (tdo !== o) port_bad = 1'b1;
	endtask
	// From Idle through capture, n shift bits LSB first, update, back to Idle
	task automatic scan(input bit ir, input int n, input logic [364:0] din,
		output logic [364:0] dout);
		logic o;
		logic oe;
		dout = '0;
		tick(1'h1, 1'h0, o, oe);
		if (ir) tick(1'h1, 1'h0, o, oe);
		tick(1'h0, 1'h0, o, oe);
		tick(1'h0, 1'h0, o, oe);
		if (oe !== 1'h0) port_bad = 1'b1;
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o, oe);
			dout[i] = o;
			if (oe !== 1'h1) port_bad = 1'b1;
		end
		tick(1'h1, 1'h0, o, oe);
		tick(1'h0, 1'h0, o, oe);
	endtask
	task automatic to_reset();
		logic o;
		logic oe;
		repeat (5) tick(1'h1, 1'h0, o, oe);
		tick(1'h0, 1'h0, o, oe);
	endtask
	// Clock stands still low so a reset is not followed by a stray rise
	task automatic park();
		@(posedge ref_clk);
		tck <= 1'h0;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule

// ---- dv/testbench.sv ----
/*
 * Self-checking bench for the boundary-scan port: identity, bypass,
 * sample, external and scan-test drive, and every reset path.
 * Assumes the scan_master model drives the test port.
 */
`timescale 1ns/1ns
module testbench;
	// Arbitrary identity value, bit 0 set
	localparam logic [31:0] ID_V = 32'h3C5A_0F01;
	localparam scan_pkg::pin_out_t PO = '{1'h1, 1'h1, 1'h0, 1'h1, 32'h5A5A_C33C,
		32'hF0F0_0FF1, 1'h0, 1'h1};
	logic               ref_clk;
	logic               rst;
	logic               trst_n;
	logic               tck;
	logic               tms;
	logic               tdi;
	logic               tdo;
	logic               tdo_oe;
	logic               o;
	logic               oe;
	logic [364:0]       dout;
	scan_pkg::pin_in_t  pins_in;
	scan_pkg::pin_out_t core_out;
	scan_pkg::pin_out_t pins_out;
	int                 mismatches;
	int                 check_count;
	int                 cycles;

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	boundary_scan_tap #(.ID_VALUE(ID_V)) u_boundary_scan_tap (
		.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdo_oe(tdo_oe), .pins_in(pins_in), .core_out(core_out),
		.pins_out(pins_out));
	scan_master u_scan_master (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe));

	task automatic check(input logic [364:0] seen, input logic [364:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d, check_count %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Expected content of the pinned cells 0..117
	function automatic logic [117:0] cells(input scan_pkg::pin_in_t pi,
		input scan_pkg::pin_out_t po);
		logic [117:0] v;
		int b;
		v = '0;
		v[0] = po.rx_bus_clock_oe;
		v[1] = po.rx_bus_clock_out;
		v[2] = po.rx_bus_data_oe;
		v[3] = po.rx_bus_data_out;
		v[4] = pi.tx_8m_data_clock_in;
		v[5] = pi.tx_8m_frame_pulse_in;
		v[6] = pi.tx_8m_frame_pulse_clock_in;
		for (int g = 0; g < 4; g++) begin
			v[7 + 26 * g] = pi.tx_frame_pulse_in[g];
			v[8 + 26 * g] = pi.tx_multiplex_clock_in[g];
		end
		for (int c = 0; c < 32; c++) begin
			b = 9 + 3 * c + 2 * (c / 8);
			v[b] = po.tx_line_data_oe[c];
			v[b + 1] = (c < 16) ? po.tx_line_data[c] : pi.tx_line_data_in_hi[c - 16];
			v[b + 2] = pi.tx_line_clock_in[c];
		end
		v[111] = pi.tx_bus_data_in;
		v[112] = po.tx_bus_clock_oe;
		v[113] = po.tx_bus_clock_out;
		v[114] = pi.production_test_enable;
		return v;
	endfunction
	task automatic ir_load(input logic [2:0] code);
		u_scan_master.scan(1'b1, 3, 365'(code), dout);
		check(365'(dout[2:0]), 365'(3'h1), "instruction capture");
	endtask
	task automatic t_idcode();
		u_scan_master.tick(1'h0, 1'h0, o, oe);
		u_scan_master.scan(1'b0, 33, 365'h1, dout);
		check(365'(dout[31:0]), 365'(ID_V), "identity after reset");
		check(365'(dout[32]), 365'h1, "identity length");
	endtask
	task automatic t_bypass();
		logic [2:0] codes [4];
		codes = '{3'h3, 3'h4, 3'h6, 3'h7};
		foreach (codes[i]) begin
			ir_load(codes[i]);
			u_scan_master.scan(1'b0, 8, 365'hB5, dout);
			check(365'(dout[7:0]), 365'h6A, "bypass path");
		end
	endtask
	task automatic t_sample();
		logic [117:0] ex;
		ir_load(scan_pkg::IR_SAMPLE);
		check(365'(pins_out), 365'(core_out), "sample keeps pins functional");
		u_scan_master.scan(1'b0, 365, '0, dout);
		ex = cells(pins_in, core_out);
		// Cells beyond 117 are masked off
		check(365'(dout[60:0]), 365'(ex[60:0]), "sample capture low");
		check(365'(dout[117:61]), 365'(ex[117:61]), "sample capture high");
	endtask
	task automatic t_drive();
		logic [2:0]         codes [2];
		scan_pkg::pin_in_t  pi_w;
		scan_pkg::pin_out_t po_x;
		logic [364:0]       din;
		codes = '{scan_pkg::IR_EXTEST, scan_pkg::IR_SCAN_TEST};
		foreach (codes[i]) begin
			po_x = codes[i][0] ? scan_pkg::pin_out_t'(~PO) : PO;
			pi_w = pins_in;
			pi_w.tx_line_data_in_hi = po_x.tx_line_data[31:16];
			// Unpinned cells get zero except the tied cells, written on purpose
			din = 365'(cells(pi_w, po_x));
			din[117:115] = 3'h7;
			ir_load(codes[i]);
			u_scan_master.scan(1'b0, 365, din, dout);
			check(365'(pins_out), 365'(po_x), "pins follow update cells");
			u_scan_master.scan(1'b0, 365, din, dout);
			check(365'(dout[117:0]), 365'(cells(pins_in, po_x)), "drive capture");
			ir_load(3'h3);
			check(365'(pins_out), 365'(core_out), "pins back to core");
		end
	endtask
	task automatic t_resets();
		for (int k = 0; k < 3; k++) begin
			ir_load(3'h3);
			if (k == 2) begin
				u_scan_master.tick(1'h1, 1'h0, o, oe);
				u_scan_master.tick(1'h0, 1'h0, o, oe);
				u_scan_master.tick(1'h0, 1'h0, o, oe);
				u_scan_master.to_reset();
			end else begin
				u_scan_master.park();
				if (k == 0) rst <= 1'h1;
				else trst_n <= 1'h0;
				repeat (4) @(posedge ref_clk);
				rst <= 1'h0;
				trst_n <= 1'h1;
				repeat (4) @(posedge ref_clk);
				u_scan_master.tick(1'h0, 1'h0, o, oe);
			end
			u_scan_master.scan(1'b0, 32, '0, dout);
			check(365'(dout[31:0]), 365'(ID_V), "reset selects identity");
		end
	endtask

	// Ceiling is about twice the expected run length
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			mismatches++;
			close_out();
		end
	end

	initial begin
		rst = 1'h1;
		trst_n = 1'h1;
		pins_in = '{1'h1, 1'h0, 1'h1, 4'h9, 4'h6, 32'h8001_4003, 16'hA501, 1'h1, 1'h1};
		core_out = '1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'h0;
		repeat (3) @(posedge ref_clk);
		t_idcode();
		t_bypass();
		t_sample();
		t_drive();
		t_resets();
		check(365'(u_scan_master.port_bad), 365'h0, "tdo timing and enable");
		close_out();
	end
endmodule

// ---- logic/boundary_scan_tap.sv ----
/*
 * Boundary-scan test access port: controller, instruction register,
 * bypass, identification and boundary chain with pin muxing.
 * Assumes the test clock is much slower than ref_clk (at least 8x)
 * and that all test-port and pin inputs are asynchronous levels.
 */
`timescale 1ns/1ns
// Function
// - Writes to unused test-mode bits change nothing inside the block.
// - Unused bits may read either value; the tester masks them off.
// - Writable test bits are not reset unless stated otherwise.
// - Port holds a controller and four scan registers.
// - Tester can sample inputs, force outputs, read identity, bypass.
// - Three-bit instruction; each code selects one data register.
// - Code 000 selects chain in external test; update cells drive pins.
// - Code 001 selects the 32-bit identification register.
// - Code 010 selects chain in sample mode; pins stay functional.
// - Codes 011, 100, 110, 111 select the one-bit bypass.
// - Code 101 selects the chain for the scan-test instruction.
// - Identification holds version, part number and maker code.
// - Chain has 365 cells: input, output and bidirectional.
// - Bit 0 receive clock enable cell, bit 1 its output cell.
// - Each transmit line has enable cell just before data cell.
// - Transmit lines 16 to 31 use bidirectional cells from bit 62.
// - Production test enable observed at chain bit 114.
// - Bits 115 to 117 are input cells tied to zero.
module boundary_scan_tap #(
	// Arbitrary neutral identity; bit 0 must stay one
	parameter logic [31:0] ID_VALUE = 32'h1000_1001
) (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic               tck,
	input  wire logic               tms,
	input  wire logic               tdi,
	input  wire logic               trst_n,
	output logic                    tdo,
	output logic                    tdo_oe,
	input  wire scan_pkg::pin_in_t  pins_in,
	input  wire scan_pkg::pin_out_t core_out,
	output scan_pkg::pin_out_t      pins_out
);

	localparam int unsigned SYNC_W = 4 + $bits(scan_pkg::pin_in_t);

	typedef struct packed {
		scan_pkg::tap_state_t                  st;
		logic                                  tck_prev;
		logic [2:0]                            tms_hi;
		logic [scan_pkg::IR_LEN-1:0]           ir_sh;
		logic [scan_pkg::IR_LEN-1:0]           ir;
		logic [scan_pkg::BS_LEN-1:0]           bs_sh;
		logic [scan_pkg::BS_PINNED-1:0]        bs_upd;
		logic [scan_pkg::ID_LEN-1:0]           id_sh;
		logic                                  by_sh;
		logic                                  tdo;
		logic                                  tdo_oe;
		scan_pkg::pin_out_t                    pins;
	} tap_regs_t;

	tap_regs_t              q;
	tap_regs_t              d;
	logic [SYNC_W-1:0]      sync_vec;
	logic                   tck_s;
	logic                   tms_s;
	logic                   tdi_s;
	logic                   trst_n_s;
	scan_pkg::pin_in_t      pin_s;
	logic                   rise;
	logic                   fall;
	logic                   bs_sel;
	logic                   id_sel;
	logic                   drive_sel;
	wire  [scan_pkg::BS_PINNED-1:0] cap_vec;
	wire  [31:0]            upd_txd;
	wire  [31:0]            upd_txd_oe;

	pin_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in ({tck, tms, tdi, trst_n, pins_in}),
		.sync_out (sync_vec)
	);

	assign {tck_s, tms_s, tdi_s, trst_n_s, pin_s} = sync_vec;

	function automatic scan_pkg::tap_state_t tap_next(scan_pkg::tap_state_t s, logic m);
		case (s)
			scan_pkg::ST_RESET:      tap_next = m ? scan_pkg::ST_RESET : scan_pkg::ST_IDLE;
			scan_pkg::ST_IDLE:       tap_next = m ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
			scan_pkg::ST_SEL_DR:     tap_next = m ? scan_pkg::ST_SEL_IR : scan_pkg::ST_CAPTURE_DR;
			scan_pkg::ST_CAPTURE_DR: tap_next = m ? scan_pkg::ST_EXIT1_DR : scan_pkg::ST_SHIFT_DR;
			scan_pkg::ST_SHIFT_DR:   tap_next = m ? scan_pkg::ST_EXIT1_DR : scan_pkg::ST_SHIFT_DR;
			scan_pkg::ST_EXIT1_DR:   tap_next = m ? scan_pkg::ST_UPDATE_DR : scan_pkg::ST_PAUSE_DR;
			scan_pkg::ST_PAUSE_DR:   tap_next = m ? scan_pkg::ST_EXIT2_DR : scan_pkg::ST_PAUSE_DR;
			scan_pkg::ST_EXIT2_DR:   tap_next = m ? scan_pkg::ST_UPDATE_DR : scan_pkg::ST_SHIFT_DR;
			scan_pkg::ST_UPDATE_DR:  tap_next = m ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
			scan_pkg::ST_SEL_IR:     tap_next = m ? scan_pkg::ST_RESET : scan_pkg::ST_CAPTURE_IR;
			scan_pkg::ST_CAPTURE_IR: tap_next = m ? scan_pkg::ST_EXIT1_IR : scan_pkg::ST_SHIFT_IR;
			scan_pkg::ST_SHIFT_IR:   tap_next = m ? scan_pkg::ST_EXIT1_IR : scan_pkg::ST_SHIFT_IR;
			scan_pkg::ST_EXIT1_IR:   tap_next = m ? scan_pkg::ST_UPDATE_IR : scan_pkg::ST_PAUSE_IR;
			scan_pkg::ST_PAUSE_IR:   tap_next = m ? scan_pkg::ST_EXIT2_IR : scan_pkg::ST_PAUSE_IR;
			scan_pkg::ST_EXIT2_IR:   tap_next = m ? scan_pkg::ST_UPDATE_IR : scan_pkg::ST_SHIFT_IR;
			scan_pkg::ST_UPDATE_IR:  tap_next = m ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
			default:                 tap_next = scan_pkg::ST_RESET;
		endcase
	endfunction

	// Fixed cells: receive bus pins, 8M inputs, bus side and tied cells
	assign cap_vec[scan_pkg::CELL_RXC_OE]    = q.pins.rx_bus_clock_oe;
	assign cap_vec[scan_pkg::CELL_RXC]       = q.pins.rx_bus_clock_out;
	assign cap_vec[scan_pkg::CELL_RXD_OE]    = q.pins.rx_bus_data_oe;
	assign cap_vec[scan_pkg::CELL_RXD]       = q.pins.rx_bus_data_out;
	assign cap_vec[scan_pkg::CELL_8M_DCLK]   = pin_s.tx_8m_data_clock_in;
	assign cap_vec[scan_pkg::CELL_8M_FP]     = pin_s.tx_8m_frame_pulse_in;
	assign cap_vec[scan_pkg::CELL_8M_FPCLK]  = pin_s.tx_8m_frame_pulse_clock_in;
	assign cap_vec[scan_pkg::CELL_TXBD]      = pin_s.tx_bus_data_in;
	assign cap_vec[scan_pkg::CELL_TXBC_OE]   = q.pins.tx_bus_clock_oe;
	assign cap_vec[scan_pkg::CELL_TXBC]      = q.pins.tx_bus_clock_out;
	assign cap_vec[scan_pkg::CELL_PROD_TEST] = pin_s.production_test_enable;
	// No pin behind these cells, so they always capture zero
	assign cap_vec[scan_pkg::CELL_TIE_HI:scan_pkg::CELL_TIE_LO] = 3'h0;

	genvar g;
	generate
		for (g = 0; g < scan_pkg::TX_GROUPS; g++) begin : g_grp
			localparam int unsigned FP = scan_pkg::CELL_GRP_BASE + scan_pkg::CELL_GRP_STEP * g;
			assign cap_vec[FP]     = pin_s.tx_frame_pulse_in[g];
			assign cap_vec[FP + 1] = pin_s.tx_multiplex_clock_in[g];
		end
		for (g = 0; g < scan_pkg::TX_LINES; g++) begin : g_line
			// Enable cell, data cell, line clock cell; two extra per group
			localparam int unsigned OE = scan_pkg::CELL_TX_BASE + 3 * g + 2 * (g / 8);
			assign cap_vec[OE]     = q.pins.tx_line_data_oe[g];
			assign cap_vec[OE + 2] = pin_s.tx_line_clock_in[g];
			assign upd_txd_oe[g]   = q.bs_upd[OE];
			assign upd_txd[g]      = q.bs_upd[OE + 1];
			if (g >= scan_pkg::IO_FIRST_LINE) begin : g_io
				// Bidirectional cell observes the pad itself
				assign cap_vec[OE + 1] = pin_s.tx_line_data_in_hi[g - scan_pkg::IO_FIRST_LINE];
			end else begin : g_out
				assign cap_vec[OE + 1] = q.pins.tx_line_data[g];
			end
		end
	endgenerate

	// Decode of the three-bit instruction; all other codes pick bypass
	assign bs_sel    = (q.ir == scan_pkg::IR_EXTEST) || (q.ir == scan_pkg::IR_SAMPLE) ||
	                   (q.ir == scan_pkg::IR_SCAN_TEST);
	assign id_sel    = (q.ir == scan_pkg::IR_IDCODE);
	assign drive_sel = (q.ir == scan_pkg::IR_EXTEST) || (q.ir == scan_pkg::IR_SCAN_TEST);
	assign rise      = tck_s & ~q.tck_prev;
	assign fall      = ~tck_s & q.tck_prev;

	always_comb begin
		d = q;
		d.tck_prev = tck_s;
		if (rise) begin
			d.st = tap_next(q.st, tms_s);
			d.tms_hi = !tms_s ? 3'h0 : (q.tms_hi == scan_pkg::TMS_CNT_MAX) ?
			           q.tms_hi : q.tms_hi + 3'h1;
			case (q.st)
				scan_pkg::ST_CAPTURE_IR: begin
					d.ir_sh = scan_pkg::IR_CAPTURE;
				end
				scan_pkg::ST_SHIFT_IR: begin
					d.ir_sh = {tdi_s, q.ir_sh[scan_pkg::IR_LEN-1:1]};
				end
				scan_pkg::ST_CAPTURE_DR: begin
					d.by_sh = 1'b0;
					d.id_sh = ID_VALUE;
					if (bs_sel) begin
						d.bs_sh = {{(scan_pkg::BS_LEN - scan_pkg::BS_PINNED){1'b0}}, cap_vec};
					end
				end
				scan_pkg::ST_SHIFT_DR: begin
					if (bs_sel) begin
						d.bs_sh = {tdi_s, q.bs_sh[scan_pkg::BS_LEN-1:1]};
					end else if (id_sel) begin
						d.id_sh = {tdi_s, q.id_sh[scan_pkg::ID_LEN-1:1]};
					end else begin
						d.by_sh = tdi_s;
					end
				end
				default: begin
					d.by_sh = q.by_sh;
				end
			endcase
		end
		if (fall) begin
			// Output moves on the falling edge so the tester samples it on the rise
			d.tdo_oe = (q.st == scan_pkg::ST_SHIFT_IR) || (q.st == scan_pkg::ST_SHIFT_DR);
			if (q.st == scan_pkg::ST_SHIFT_IR) begin
				d.tdo = q.ir_sh[0];
			end else if (q.st == scan_pkg::ST_SHIFT_DR) begin
				d.tdo = bs_sel ? q.bs_sh[0] : id_sel ? q.id_sh[0] : q.by_sh;
			end
			if (q.st == scan_pkg::ST_UPDATE_IR) begin
				d.ir = q.ir_sh;
			end
			// Cells beyond the pinned range have no update stage to change
			if (q.st == scan_pkg::ST_UPDATE_DR && bs_sel) begin
				d.bs_upd = q.bs_sh[scan_pkg::BS_PINNED-1:0];
			end
		end
		if (q.st == scan_pkg::ST_RESET) begin
			d.ir = scan_pkg::IR_IDCODE;
		end
		if (!trst_n_s) begin
			d.st = scan_pkg::ST_RESET;
		end
		// Pins follow the core unless an external or scan test is in force
		if (drive_sel) begin
			d.pins.rx_bus_clock_oe  = q.bs_upd[scan_pkg::CELL_RXC_OE];
			d.pins.rx_bus_clock_out = q.bs_upd[scan_pkg::CELL_RXC];
			d.pins.rx_bus_data_oe   = q.bs_upd[scan_pkg::CELL_RXD_OE];
			d.pins.rx_bus_data_out  = q.bs_upd[scan_pkg::CELL_RXD];
			d.pins.tx_line_data_oe  = upd_txd_oe;
			d.pins.tx_line_data     = upd_txd;
			d.pins.tx_bus_clock_oe  = q.bs_upd[scan_pkg::CELL_TXBC_OE];
			d.pins.tx_bus_clock_out = q.bs_upd[scan_pkg::CELL_TXBC];
		end else begin
			d.pins = core_out;
		end
		if (rst) begin
			// Boundary update and shift stages keep their contents through reset
			d.st       = scan_pkg::ST_RESET;
			d.tck_prev = 1'b0;
			d.tms_hi   = 3'h0;
			d.ir_sh    = scan_pkg::IR_CAPTURE;
			d.ir       = scan_pkg::IR_IDCODE;
			d.id_sh    = '0;
			d.by_sh    = 1'b0;
			d.tdo      = 1'b0;
			d.tdo_oe   = 1'b0;
			d.pins     = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		q <= d;
	end

	assign tdo      = q.tdo;
	assign tdo_oe   = q.tdo_oe;
	assign pins_out = q.pins;

	a_tms_reset: assert property (@(posedge ref_clk) disable iff (rst)
		(q.tms_hi >= scan_pkg::TMS_RESET_CNT) |-> (q.st == scan_pkg::ST_RESET))
		else $error("five high TMS clocks did not reach reset");

	a_reset_selects_id: assert property (@(posedge ref_clk) disable iff (rst)
		(q.st == scan_pkg::ST_RESET) |=> (q.ir == scan_pkg::IR_IDCODE))
		else $error("reset state did not select identification");

	a_tdo_on_fall: assert property (@(posedge ref_clk) disable iff (rst)
		($changed(q.tdo) || $changed(q.tdo_oe)) |-> $past(fall))
		else $error("test data out changed off a falling edge");

	a_extest_drive: assert property (@(posedge ref_clk) disable iff (rst)
		(q.ir == scan_pkg::IR_EXTEST) |=>
		(q.pins.tx_line_data[0] == $past(q.bs_upd[10]) &&
		 q.pins.tx_line_data_oe[0] == $past(q.bs_upd[9])))
		else $error("external test did not drive line 0 from cells 9 and 10");

	a_sample_pass: assert property (@(posedge ref_clk) disable iff (rst)
		(q.ir == scan_pkg::IR_SAMPLE) |=> (q.pins == $past(core_out)))
		else $error("sample mode disturbed the functional pins");

	a_bypass_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(rise && q.st == scan_pkg::ST_CAPTURE_DR && !bs_sel && !id_sel) |=> !q.by_sh)
		else $error("bypass did not capture zero");

	a_id_capture: assert property (@(posedge ref_clk) disable iff (rst)
		(rise && q.st == scan_pkg::ST_CAPTURE_DR && id_sel) |=> (q.id_sh == ID_VALUE))
		else $error("identification capture wrong");

	a_tied_cells: assert property (@(posedge ref_clk) disable iff (rst)
		(rise && q.st == scan_pkg::ST_CAPTURE_DR && bs_sel) |=>
		(q.bs_sh[117:115] == 3'h0 && q.bs_sh[114] == $past(pin_s.production_test_enable)))
		else $error("tied or production test cells captured wrongly");

	a_io_cell: assert property (@(posedge ref_clk) disable iff (rst)
		(rise && q.st == scan_pkg::ST_CAPTURE_DR && bs_sel) |=>
		(q.bs_sh[62] == $past(pin_s.tx_line_data_in_hi[0])))
		else $error("line 16 bidirectional cell did not observe its pad");

	a_ir_capture: assert property (@(posedge ref_clk) disable iff (rst)
		(rise && q.st == scan_pkg::ST_CAPTURE_IR) |=> (q.ir_sh == scan_pkg::IR_CAPTURE))
		else $error("instruction capture pattern wrong");

	// Cells without pins must read back a known level after capture
	a_unused_cells: assert property (@(posedge ref_clk) disable iff (rst)
		(rise && q.st == scan_pkg::ST_CAPTURE_DR && bs_sel) |=>
		(q.bs_sh[scan_pkg::BS_LEN-1:scan_pkg::BS_PINNED] == '0))
		else $error("cells without pins did not capture zero");

	a_core_pins: assert property (@(posedge ref_clk) disable iff (rst)
		!drive_sel |=> (q.pins == $past(core_out)))
		else $error("pins left the core values outside a drive instruction");

endmodule

// ---- logic/pin_sync.sv ----
/*
 * Two-stage synchroniser for a vector of asynchronous levels.
 * Assumes each bit is a level that stays put for several clocks.
 */
`timescale 1ns/1ns
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	// The first stage feeds only the second stage
	always_comb begin
		d = q;
		d.meta = async_in;
		d.held = q.meta;
		if (rst) begin
			d = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		q <= d;
	end

	assign sync_out = q.held;

endmodule

// ---- logic/scan_pkg.sv ----
/*
 * Shared constants and carriers of the boundary-scan test port:
 * instruction codes, chain geometry, cell positions and pin bundles.
 * Assumes a single system clock samples the test clock and all pins.
 */
package scan_pkg;

	localparam int unsigned IR_LEN         = 3;
	localparam int unsigned ID_LEN         = 32;
	localparam int unsigned BS_LEN         = 365;
	localparam int unsigned BS_PINNED      = 118;
	localparam int unsigned TX_LINES       = 32;
	localparam int unsigned TX_GROUPS      = 4;
	localparam int unsigned IO_FIRST_LINE  = 16;

	localparam logic [2:0] IR_EXTEST       = 3'h0;
	localparam logic [2:0] IR_IDCODE       = 3'h1;
	localparam logic [2:0] IR_SAMPLE       = 3'h2;
	localparam logic [2:0] IR_SCAN_TEST    = 3'h5;
	localparam logic [2:0] IR_CAPTURE      = 3'h1;

	localparam int unsigned CELL_RXC_OE    = 0;
	localparam int unsigned CELL_RXC       = 1;
	localparam int unsigned CELL_RXD_OE    = 2;
	localparam int unsigned CELL_RXD       = 3;
	localparam int unsigned CELL_8M_DCLK   = 4;
	localparam int unsigned CELL_8M_FP     = 5;
	localparam int unsigned CELL_8M_FPCLK  = 6;
	localparam int unsigned CELL_GRP_BASE  = 7;
	localparam int unsigned CELL_GRP_STEP  = 26;
	localparam int unsigned CELL_TX_BASE   = 9;
	localparam int unsigned CELL_TXBD      = 111;
	localparam int unsigned CELL_TXBC_OE   = 112;
	localparam int unsigned CELL_TXBC      = 113;
	localparam int unsigned CELL_PROD_TEST = 114;
	localparam int unsigned CELL_TIE_LO    = 115;
	localparam int unsigned CELL_TIE_HI    = 117;

	localparam logic [2:0] TMS_RESET_CNT   = 3'h5;
	localparam logic [2:0] TMS_CNT_MAX     = 3'h7;

	typedef enum logic [15:0] {
		ST_RESET      = 16'h0001,
		ST_IDLE       = 16'h0002,
		ST_SEL_DR     = 16'h0004,
		ST_CAPTURE_DR = 16'h0008,
		ST_SHIFT_DR   = 16'h0010,
		ST_EXIT1_DR   = 16'h0020,
		ST_PAUSE_DR   = 16'h0040,
		ST_EXIT2_DR   = 16'h0080,
		ST_UPDATE_DR  = 16'h0100,
		ST_SEL_IR     = 16'h0200,
		ST_CAPTURE_IR = 16'h0400,
		ST_SHIFT_IR   = 16'h0800,
		ST_EXIT1_IR   = 16'h1000,
		ST_PAUSE_IR   = 16'h2000,
		ST_EXIT2_IR   = 16'h4000,
		ST_UPDATE_IR  = 16'h8000
	} tap_state_t;

	typedef struct packed {
		logic        tx_8m_data_clock_in;
		logic        tx_8m_frame_pulse_in;
		logic        tx_8m_frame_pulse_clock_in;
		logic [3:0]  tx_frame_pulse_in;
		logic [3:0]  tx_multiplex_clock_in;
		logic [31:0] tx_line_clock_in;
		logic [15:0] tx_line_data_in_hi;
		logic        tx_bus_data_in;
		logic        production_test_enable;
	} pin_in_t;

	typedef struct packed {
		logic        rx_bus_clock_out;
		logic        rx_bus_clock_oe;
		logic        rx_bus_data_out;
		logic        rx_bus_data_oe;
		logic [31:0] tx_line_data;
		logic [31:0] tx_line_data_oe;
		logic        tx_bus_clock_out;
		logic        tx_bus_clock_oe;
	} pin_out_t;

endpackage
